// ==== rlp_pkg.sv ====
// shared constants and types of the rgb pixel output path
package rlp_pkg;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_MASK = 8'h08;
   localparam logic [7:0] A_NDP  = 8'h0C;
   localparam logic [7:0] A_XCNT = 8'h10;
   localparam logic [7:0] A_YCNT = 8'h14;
   localparam logic [7:0] A_XMOD = 8'h18;
   localparam logic [7:0] A_YMOD = 8'h1C;
   localparam logic [7:0] A_PDLY = 8'h20;
   localparam logic [7:0] A_PCNT = 8'h24;
   localparam logic [7:0] A_CSCI = 8'h28;
   localparam logic [7:0] A_CSCO = 8'h2C;
   localparam logic [7:0] A_FDIR = 8'h30;
   localparam logic [7:0] A_FDAT = 8'h34;
   localparam logic [7:0] A_TMR  = 8'h40;
   localparam logic [7:0] TMR_STRIDE = 8'h10;
   localparam logic [7:0] TMR_PER    = 8'h00;
   localparam logic [7:0] TMR_WID    = 8'h04;
   localparam logic [7:0] TMR_CFG    = 8'h08;
   localparam int NUM_TMR = 5;
   // field positions
   localparam int CTRL_EN   = 0;
   localparam int ST_DONE   = 0;
   localparam int ST_UNDR   = 1;
   localparam int NUM_ST    = 2;
   localparam int CFG_TEN   = 0;
   localparam int CFG_POL   = 1;
   localparam int FLAG_BIT  = 8;
   localparam int DCFG_DI   = 7;
   // reset values
   localparam logic [15:0] XCNT_RST = 16'h0078;
   localparam logic [15:0] YCNT_RST = 16'h0149;
   localparam logic [15:0] MOD_RST  = 16'h0004;
   localparam logic [15:0] PDLY_RST = 16'h0000;
   localparam logic [15:0] PCNT_RST = 16'h00EF;
   localparam logic [31:0] NDP_RST  = 32'h0000_0000;
   // converter fixed point, coefficients scaled by 1024
   localparam int          FRAC     = 10;
   localparam logic signed [19:0] K_RV  = 20'sh0057C;
   localparam logic signed [19:0] K_GU  = 20'sh002CB;
   localparam logic signed [19:0] K_GV  = 20'sh00158;
   localparam logic signed [19:0] K_BU  = 20'sh006EE;
   localparam logic signed [19:0] C_OFS = 20'sh00080;
   localparam logic signed [19:0] C_RND = 20'sh00200;
   localparam logic signed [19:0] C_MAX = 20'sh000FF;
   typedef enum logic [1:0] {D_IDLE, D_DESC, D_DATA} rlp_dma_t;
   typedef enum logic [1:0] {P_IDLE, P_SYNC, P_WAIT, P_DATA} rlp_port_t;
endpackage : rlp_pkg

// ==== rlp_csc.sv ====
// luminance/chrominance to 5-6-5 rgb converter
`timescale 1ns/100ps
module rlp_csc (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        in_valid,
   input  wire logic [7:0]  y,
   input  wire logic [7:0]  cb,
   input  wire logic [7:0]  cr,
   output logic      [15:0] pix
);
   logic signed [19:0] yv, dcb, dcr, rs, gs, bs;
   logic        [7:0]  r8, g8, b8;
   logic        [15:0] pix_d, pix_q;

   function automatic logic [7:0] sat(input logic signed [19:0] v);
      logic signed [19:0] s;
      s = (v + rlp_pkg::C_RND) >>> rlp_pkg::FRAC;
      if (s < 0) sat = 8'h00;
      else if (s > rlp_pkg::C_MAX) sat = 8'hFF;
      else sat = s[7:0];
   endfunction : sat

   always_comb begin
      yv  = $signed({2'b00, y, 10'h000});
      dcb = $signed({12'h000, cb}) - rlp_pkg::C_OFS;
      dcr = $signed({12'h000, cr}) - rlp_pkg::C_OFS;
      rs  = yv + rlp_pkg::K_RV * dcr;
      gs  = yv - rlp_pkg::K_GU * dcb - rlp_pkg::K_GV * dcr;
      bs  = yv + rlp_pkg::K_BU * dcb;
      r8  = sat(rs);
      g8  = sat(gs);
      b8  = sat(bs);
      pix_d = in_valid ? {r8[7:3], g8[7:2], b8[7:3]} : pix_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) pix_q <= 16'h0000;
      else if (ce) pix_q <= pix_d;
   end

   assign pix = pix_q;
endmodule : rlp_csc

// ==== rlp_pwm.sv ====
// one pwm timing-signal timer on the system clock
`timescale 1ns/100ps
module rlp_pwm #(
   parameter int W = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         en,
   input  wire logic         pol,
   input  wire logic [W-1:0] per,
   input  wire logic [W-1:0] wid,
   output logic              pwm_out
);
   logic [W-1:0] cnt_d, cnt_q;
   logic         out_d, out_q;

   always_comb begin
      if (!en || cnt_q >= per - W'(1)) cnt_d = '0;
      else cnt_d = cnt_q + W'(1);
      // idle at the inactive level so the panel sees no stray pulse
      out_d = en ? ((cnt_q < wid) ~^ pol) : ~pol;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign pwm_out = out_q;
endmodule : rlp_pwm

// ==== rlp_top.sv ====
// rgb pixel output path: transfer channel, video port, timers, flag pin
// Behaviour
// - rgb from y, cb, cr with fixed coefficients
// - each converted component held as eight bits
// - reduce pixel to 5-6-5 sixteen bits
// - port carries at most sixteen data bits
// - 120 words per row, 329 rows
// - address advances four bytes per word
// - descriptor list, 32-bit words, completion interrupt
// - fetch next pointer, low, high, config
// - descriptor links to itself, frame replays
// - one frame sync marks each line
// - data after delay plus one port clock
// - count plus one words per line
// - general transmit, single sync, sixteen bits
// - five timer outputs and one flag pin
// - timers pwm with period, width, polarity
// - flag pin 8 direction and data
// - frame completion raises interrupt, next starts
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module rlp_top (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq,
   output logic             mem_rd,
   output logic      [31:0] mem_addr,
   input  wire logic        mem_rvalid,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        video_port_clock,
   output logic      [15:0] video_data,
   output logic             line_frame_sync_out,
   output logic      [4:0]  timing_out,
   input  wire logic        panel_mode_flag_pin_i,
   output logic             panel_mode_flag_pin_o,
   output logic             panel_mode_flag_pin_oe
);
   localparam int NT = rlp_pkg::NUM_TMR;

   // register state
   logic                    en_d, en_q, fdir_d, fdir_q, fdat_d, fdat_q;
   logic [rlp_pkg::NUM_ST-1:0] stat_d, stat_q, mask_d, mask_q, stat_set;
   logic [31:0]             ndp_d, ndp_q, rdata_d, rdata_q;
   logic [15:0]             xcnt_d, xcnt_q, ycnt_d, ycnt_q, xmod_d, xmod_q;
   logic [15:0]             ymod_d, ymod_q, pdly_d, pdly_q, pcnt_d, pcnt_q;
   logic [31:0]             per_d [NT], per_q [NT], wid_d [NT], wid_q [NT];
   logic [1:0]              tcfg_d [NT], tcfg_q [NT];
   logic                    csc_wr;
   logic [15:0]             csc_pix;
   // synchronisers
   logic                    vclk_s1, vclk_s2, vclk_s3, flag_s1, flag_s2, tick;
   // transfer channel
   rlp_pkg::rlp_dma_t       dma_d, dma_q;
   logic [31:0]             desc_d, desc_q, addr_d, addr_q, maddr_d, maddr_q;
   logic [31:0]             word_d, word_q, nxt_val;
   logic [15:0]             xi_d, xi_q, yi_d, yi_q, dcfg_d, dcfg_q;
   logic [1:0]              el_d, el_q;
   logic                    pend_d, pend_q, mrd_d, mrd_q, full_d, full_q;
   logic                    last_d, last_q, fin_d, fin_q, done, ld_nxt;
   // video port
   rlp_pkg::rlp_port_t      prt_d, prt_q;
   logic [15:0]             vd_d, vd_q, wc_d, wc_q, pc_d, pc_q;
   logic                    fs_d, fs_q, half_d, half_q, emit, take, undr;

   assign tick   = vclk_s2 & ~vclk_s3;
   assign csc_wr = reg_wr && reg_addr == rlp_pkg::A_CSCI;

   // ---------------- register file ----------------
   always_comb begin
      en_d = en_q; mask_d = mask_q; ndp_d = ndp_q; xcnt_d = xcnt_q; ycnt_d = ycnt_q;
      xmod_d = xmod_q; ymod_d = ymod_q; pdly_d = pdly_q; pcnt_d = pcnt_q;
      fdir_d = fdir_q; fdat_d = fdat_q; per_d = per_q; wid_d = wid_q; tcfg_d = tcfg_q;
      stat_d = stat_q | stat_set;
      if (ld_nxt) ndp_d = nxt_val;
      if (reg_wr) begin
         case (reg_addr)
            rlp_pkg::A_CTRL: en_d = reg_wdata[rlp_pkg::CTRL_EN];
            // set wins over a clear in the same cycle
            rlp_pkg::A_STAT: stat_d = (stat_q & ~reg_wdata[rlp_pkg::NUM_ST-1:0]) | stat_set;
            rlp_pkg::A_MASK: mask_d = reg_wdata[rlp_pkg::NUM_ST-1:0];
            rlp_pkg::A_NDP:  ndp_d  = reg_wdata;
            rlp_pkg::A_XCNT: xcnt_d = reg_wdata[15:0];
            rlp_pkg::A_YCNT: ycnt_d = reg_wdata[15:0];
            rlp_pkg::A_XMOD: xmod_d = reg_wdata[15:0];
            rlp_pkg::A_YMOD: ymod_d = reg_wdata[15:0];
            rlp_pkg::A_PDLY: pdly_d = reg_wdata[15:0];
            rlp_pkg::A_PCNT: pcnt_d = reg_wdata[15:0];
            rlp_pkg::A_FDIR: fdir_d = reg_wdata[rlp_pkg::FLAG_BIT];
            rlp_pkg::A_FDAT: fdat_d = reg_wdata[rlp_pkg::FLAG_BIT];
            default: ;
         endcase
         for (int i = 0; i < NT; i++) begin
            if (reg_addr == rlp_pkg::A_TMR + 8'(i) * rlp_pkg::TMR_STRIDE + rlp_pkg::TMR_PER)
               per_d[i] = reg_wdata;
            if (reg_addr == rlp_pkg::A_TMR + 8'(i) * rlp_pkg::TMR_STRIDE + rlp_pkg::TMR_WID)
               wid_d[i] = reg_wdata;
            if (reg_addr == rlp_pkg::A_TMR + 8'(i) * rlp_pkg::TMR_STRIDE + rlp_pkg::TMR_CFG)
               tcfg_d[i] = reg_wdata[1:0];
         end
      end
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            rlp_pkg::A_CTRL: rdata_d[rlp_pkg::CTRL_EN] = en_q;
            rlp_pkg::A_STAT: rdata_d[rlp_pkg::NUM_ST-1:0] = stat_q;
            rlp_pkg::A_MASK: rdata_d[rlp_pkg::NUM_ST-1:0] = mask_q;
            rlp_pkg::A_NDP:  rdata_d = ndp_q;
            rlp_pkg::A_XCNT: rdata_d[15:0] = xcnt_q;
            rlp_pkg::A_YCNT: rdata_d[15:0] = ycnt_q;
            rlp_pkg::A_XMOD: rdata_d[15:0] = xmod_q;
            rlp_pkg::A_YMOD: rdata_d[15:0] = ymod_q;
            rlp_pkg::A_PDLY: rdata_d[15:0] = pdly_q;
            rlp_pkg::A_PCNT: rdata_d[15:0] = pcnt_q;
            rlp_pkg::A_CSCO: rdata_d[15:0] = csc_pix;
            rlp_pkg::A_FDIR: rdata_d[rlp_pkg::FLAG_BIT] = fdir_q;
            rlp_pkg::A_FDAT: rdata_d[rlp_pkg::FLAG_BIT] = fdir_q ? fdat_q : flag_s2;
            default: ;
         endcase
         for (int i = 0; i < NT; i++) begin
            if (reg_addr == rlp_pkg::A_TMR + 8'(i) * rlp_pkg::TMR_STRIDE + rlp_pkg::TMR_PER)
               rdata_d = per_q[i];
            if (reg_addr == rlp_pkg::A_TMR + 8'(i) * rlp_pkg::TMR_STRIDE + rlp_pkg::TMR_WID)
               rdata_d = wid_q[i];
            if (reg_addr == rlp_pkg::A_TMR + 8'(i) * rlp_pkg::TMR_STRIDE + rlp_pkg::TMR_CFG)
               rdata_d[1:0] = tcfg_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         en_q <= 1'b0; stat_q <= '0; mask_q <= '0; ndp_q <= rlp_pkg::NDP_RST;
         xcnt_q <= rlp_pkg::XCNT_RST; ycnt_q <= rlp_pkg::YCNT_RST;
         xmod_q <= rlp_pkg::MOD_RST; ymod_q <= rlp_pkg::MOD_RST;
         pdly_q <= rlp_pkg::PDLY_RST; pcnt_q <= rlp_pkg::PCNT_RST;
         fdir_q <= 1'b0; fdat_q <= 1'b0; rdata_q <= 32'h0000_0000;
         for (int i = 0; i < NT; i++) begin
            per_q[i] <= 32'h0000_0000; wid_q[i] <= 32'h0000_0000; tcfg_q[i] <= 2'h0;
         end
      end else if (ce) begin
         en_q <= en_d; stat_q <= stat_d; mask_q <= mask_d; ndp_q <= ndp_d;
         xcnt_q <= xcnt_d; ycnt_q <= ycnt_d; xmod_q <= xmod_d; ymod_q <= ymod_d;
         pdly_q <= pdly_d; pcnt_q <= pcnt_d; fdir_q <= fdir_d; fdat_q <= fdat_d;
         rdata_q <= rdata_d; per_q <= per_d; wid_q <= wid_d; tcfg_q <= tcfg_d;
      end
   end

   // first stage feeds only the second; edge found on stages two and three
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         vclk_s1 <= 1'b0; vclk_s2 <= 1'b0; vclk_s3 <= 1'b0;
         flag_s1 <= 1'b0; flag_s2 <= 1'b0;
      end else if (ce) begin
         vclk_s1 <= video_port_clock; vclk_s2 <= vclk_s1; vclk_s3 <= vclk_s2;
         flag_s1 <= panel_mode_flag_pin_i; flag_s2 <= flag_s1;
      end
   end

   // ---------------- transfer channel ----------------
   always_comb begin
      dma_d = dma_q; desc_d = desc_q; el_d = el_q; pend_d = pend_q; mrd_d = 1'b0;
      maddr_d = maddr_q; addr_d = addr_q; xi_d = xi_q; yi_d = yi_q; word_d = word_q;
      full_d = full_q; last_d = last_q; fin_d = fin_q; dcfg_d = dcfg_q;
      done = 1'b0; ld_nxt = 1'b0; nxt_val = {desc_q[31:16], mem_rdata[15:0]};
      if (mem_rvalid) pend_d = 1'b0;
      if (take) begin
         full_d = 1'b0;
         done   = last_q;
      end
      case (dma_q)
         rlp_pkg::D_IDLE: if (en_q) begin
            dma_d = rlp_pkg::D_DESC; desc_d = ndp_q; el_d = 2'h0;
         end
         rlp_pkg::D_DESC: begin
            if (!pend_q) begin
               mrd_d = 1'b1; pend_d = 1'b1;
               maddr_d = desc_q + {29'h0000_0000, el_q, 1'b0};
            end else if (mem_rvalid) begin
               el_d = el_q + 2'h1;
               unique case (el_q)
                  2'h0: ld_nxt = 1'b1;
                  2'h1: addr_d[15:0] = mem_rdata[15:0];
                  2'h2: addr_d[31:16] = mem_rdata[15:0];
                  2'h3: begin
                     dcfg_d = mem_rdata[15:0]; dma_d = rlp_pkg::D_DATA;
                     xi_d = 16'h0000; yi_d = 16'h0000; fin_d = 1'b0;
                  end
               endcase
            end
         end
         rlp_pkg::D_DATA: begin
            if (!pend_q && !full_q && !fin_q) begin
               mrd_d = 1'b1; pend_d = 1'b1; maddr_d = addr_q;
            end else if (pend_q && mem_rvalid) begin
               word_d = mem_rdata; full_d = 1'b1;
               last_d = xi_q == xcnt_q - 16'h1 && yi_q == ycnt_q - 16'h1;
               fin_d  = last_d;
               if (xi_q == xcnt_q - 16'h1) begin
                  xi_d = 16'h0000; yi_d = yi_q + 16'h1;
                  addr_d = addr_q + {16'h0000, ymod_q};
               end else begin
                  xi_d = xi_q + 16'h1;
                  addr_d = addr_q + {16'h0000, xmod_q};
               end
            end
            // pointer is read here, at the frame boundary, and in D_IDLE when the channel is enabled
            if (done) begin
               dma_d = rlp_pkg::D_DESC; desc_d = ndp_q; el_d = 2'h0;
            end
         end
         default: dma_d = rlp_pkg::D_IDLE;
      endcase
      if (!en_q) begin
         dma_d = rlp_pkg::D_IDLE; full_d = 1'b0; fin_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dma_q <= rlp_pkg::D_IDLE; desc_q <= 32'h0000_0000; el_q <= 2'h0;
         pend_q <= 1'b0; mrd_q <= 1'b0; maddr_q <= 32'h0000_0000;
         addr_q <= 32'h0000_0000; xi_q <= 16'h0000; yi_q <= 16'h0000;
         word_q <= 32'h0000_0000; full_q <= 1'b0; last_q <= 1'b0; fin_q <= 1'b0;
         dcfg_q <= 16'h0000;
      end else if (ce) begin
         dma_q <= dma_d; desc_q <= desc_d; el_q <= el_d; pend_q <= pend_d;
         mrd_q <= mrd_d; maddr_q <= maddr_d; addr_q <= addr_d; xi_q <= xi_d;
         yi_q <= yi_d; word_q <= word_d; full_q <= full_d; last_q <= last_d;
         fin_q <= fin_d; dcfg_q <= dcfg_d;
      end
   end

   // ---------------- video port ----------------
   always_comb begin
      prt_d = prt_q; fs_d = fs_q; vd_d = vd_q; wc_d = wc_q; pc_d = pc_q;
      half_d = half_q; emit = 1'b0; undr = 1'b0;
      if (tick) begin
         fs_d = 1'b0;
         unique case (prt_q)
            rlp_pkg::P_IDLE: if (dma_q == rlp_pkg::D_DATA && full_q) begin
               fs_d = 1'b1; prt_d = rlp_pkg::P_SYNC; pc_d = 16'h0000;
            end
            rlp_pkg::P_SYNC: if (pdly_q == 16'h0000) emit = 1'b1;
               else begin
                  wc_d = pdly_q - 16'h1; prt_d = rlp_pkg::P_WAIT;
               end
            rlp_pkg::P_WAIT: if (wc_q == 16'h0000) emit = 1'b1;
               else wc_d = wc_q - 16'h1;
            rlp_pkg::P_DATA: emit = 1'b1;
         endcase
         if (emit) begin
            prt_d  = pc_q == pcnt_q ? rlp_pkg::P_IDLE : rlp_pkg::P_DATA;
            pc_d   = pc_q + 16'h1;
            half_d = ~half_q;
            // an empty word resends the half of the stale word_q that half_q selects rather than stalling the line
            undr   = ~full_q;
            vd_d   = half_q ? word_q[31:16] : word_q[15:0];
         end
      end
      take = emit & half_q & full_q;
      if (!en_q) begin
         prt_d = rlp_pkg::P_IDLE; fs_d = 1'b0; half_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prt_q <= rlp_pkg::P_IDLE; fs_q <= 1'b0; vd_q <= 16'h0000;
         wc_q <= 16'h0000; pc_q <= 16'h0000; half_q <= 1'b0;
      end else if (ce) begin
         prt_q <= prt_d; fs_q <= fs_d; vd_q <= vd_d;
         wc_q <= wc_d; pc_q <= pc_d; half_q <= half_d;
      end
   end

   always_comb begin
      stat_set = '0;
      stat_set[rlp_pkg::ST_DONE] = done & dcfg_q[rlp_pkg::DCFG_DI];
      stat_set[rlp_pkg::ST_UNDR] = undr;
   end

   rlp_csc u_csc (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .in_valid (csc_wr),
      .y        (reg_wdata[7:0]),
      .cb       (reg_wdata[15:8]),
      .cr       (reg_wdata[23:16]),
      .pix      (csc_pix)
   );

   for (genvar i = 0; i < NT; i++) begin : g_tmr
      rlp_pwm #(.W(32)) u_pwm (
         .clk     (ref_clk),
         .rst_n   (rst_n),
         .ce      (ce),
         .en      (tcfg_q[i][rlp_pkg::CFG_TEN]),
         .pol     (tcfg_q[i][rlp_pkg::CFG_POL]),
         .per     (per_q[i]),
         .wid     (wid_q[i]),
         .pwm_out (timing_out[i])
      );
   end

   assign reg_rdata              = rdata_q;
   assign irq                    = |(stat_q & mask_q);
   assign mem_rd                 = mrd_q;
   assign mem_addr               = maddr_q;
   assign video_data             = vd_q;
   assign line_frame_sync_out    = fs_q;
   assign panel_mode_flag_pin_o  = fdat_q;
   assign panel_mode_flag_pin_oe = fdir_q;
endmodule : rlp_top

// ==== rlp_top_asserts.sv ====
// port checker of the rgb pixel output path
`timescale 1ns/100ps
module rlp_chk (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        irq,
   input wire logic        mem_rd,
   input wire logic [31:0] mem_addr,
   input wire logic [15:0] video_data,
   input wire logic        line_frame_sync_out,
   input wire logic        panel_mode_flag_pin_o,
   input wire logic        panel_mode_flag_pin_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_req_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("read request longer than one cycle");
   a_addr_hold: assert property (!mem_rd |-> $stable(mem_addr))
      else $error("request address moved without a request");
   a_dir_write: assert property (reg_wr && reg_addr == rlp_pkg::A_FDIR
      |=> panel_mode_flag_pin_oe == $past(reg_wdata[8]))
      else $error("flag enable does not follow direction bit");
   a_flag_write: assert property (reg_wr && reg_addr == rlp_pkg::A_FDAT
      |=> panel_mode_flag_pin_o == $past(reg_wdata[8]))
      else $error("flag level does not follow data bit");
   a_mask_quiet: assert property (reg_wr && reg_addr == rlp_pkg::A_MASK
      && reg_wdata[1:0] == 2'b00 |=> !irq)
      else $error("interrupt high with all sources masked");
   a_sync_width: assert property ($rose(line_frame_sync_out)
      |=> line_frame_sync_out [*5])
      else $error("line sync shorter than a port clock");
   a_pixel_hold: assert property ($changed(video_data) |=> $stable(video_data) [*5])
      else $error("pixel word not held for a port clock");
   a_grey_pixel: assert property (reg_wr && reg_addr == rlp_pkg::A_CSCI
      && reg_wdata[23:0] == 24'h808080 ##2 reg_rd && reg_addr == rlp_pkg::A_CSCO
      |=> reg_rdata == 32'h0000_8410)
      else $error("mid grey converts wrongly");
   a_hole_read: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   c_line: cover property ($rose(line_frame_sync_out));
   c_irq: cover property ($rose(irq));
   c_fetch: cover property (mem_rd ##[1:20] mem_rd);
endmodule : rlp_chk
bind rlp_top rlp_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq(irq), .mem_rd(mem_rd), .mem_addr(mem_addr), .video_data(video_data),
   .line_frame_sync_out(line_frame_sync_out), .panel_mode_flag_pin_o(panel_mode_flag_pin_o),
   .panel_mode_flag_pin_oe(panel_mode_flag_pin_oe));

// ==== rlp_mem_model.sv ====
// frame buffer and descriptor memory seen by the transfer channel
`timescale 1ns/100ps
module rlp_mem_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        mem_rd,
   input  wire logic [31:0] mem_addr,
   output logic             mem_rvalid,
   output logic      [31:0] mem_rdata
);
   int          wait_n = -1;
   logic [31:0] addr_q = 32'h0;
   // below 0x400: descriptors at 0x100 (buffer 0x2000) and 0x200 (buffer 0x3000)
   function automatic logic [31:0] word(input logic [31:0] a);
      logic [15:0] lo;
      if (a[31:10] != 22'h0) return {~a[15:0], a[15:0]};
      case (a[2:1])
         2'd0: lo = {a[15:8], 8'h00};
         2'd1: lo = a[9] ? 16'h3000 : 16'h2000;
         2'd2: lo = 16'h0000;
         default: lo = 16'h0080;
      endcase
      return {~lo, lo};
   endfunction : word
   initial mem_rvalid = 1'b0;
   initial mem_rdata = 32'h0;
   always @(posedge clk) begin
      mem_rvalid <= 1'b0;
      // idle bus toggles so stale data never passes for an answer
      mem_rdata <= ~mem_rdata;
      if (mem_rd) begin
         addr_q <= mem_addr;
         // three is the longest wait that still refills a word within one port clock
         wait_n <= slow ? 3 : 1;
      end else if (wait_n > 0) wait_n <= wait_n - 1;
      else if (wait_n == 0) begin
         wait_n <= -1;
         mem_rvalid <= 1'b1;
         mem_rdata <= word(addr_q);
      end
   end
endmodule : rlp_mem_model

// ==== testbench.sv ====
// self-checking bench of the rgb pixel output path
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        port_clk = 1'b0;
   logic        slow = 1'b0;
   logic        ext_lvl = 1'b0;
   logic        ce = 1'b1;
   logic [31:0] reg_rdata, mem_addr, mem_rdata;
   logic        irq, mem_rd, mem_rvalid, fsync, f_o, f_oe;
   logic [15:0] video_data;
   logic [4:0]  timing_out;
   logic [15:0] cap[$];
   int          rem = 0;
   int          n_errors = 0;
   int          n_compared = 0;
   logic [7:0]  y_t[5] = '{8'h80, 8'hFF, 8'h00, 8'h5A, 8'hC8};
   logic [7:0]  u_t[5] = '{8'h80, 8'hFF, 8'h00, 8'hF0, 8'h3C};
   logic [7:0]  v_t[5] = '{8'h80, 8'hFF, 8'h00, 8'h6E, 8'hE6};
   always #10 ref_clk = ~ref_clk;
   always #80 port_clk = ~port_clk;
   rlp_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .video_port_clock(port_clk), .video_data(video_data),
      .line_frame_sync_out(fsync), .timing_out(timing_out),
      .panel_mode_flag_pin_i(f_oe ? f_o : ext_lvl), .panel_mode_flag_pin_o(f_o),
      .panel_mode_flag_pin_oe(f_oe));
   rlp_mem_model u_mem (.clk(ref_clk), .slow(slow), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   task automatic final_report;
      $display("errors %0d of %0d compared", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd
   task automatic wait_cap(input int n);
      for (int k = 0; k < 20000 && cap.size() < n; k++) @(posedge ref_clk);
      if (cap.size() < n) begin
         n_errors++;
         $display("wrong value at %0t: pixel stream stalled", $time);
         final_report();
      end
   endtask : wait_cap
   function automatic logic [15:0] px(input logic [15:0] base, input int i);
      logic [15:0] a;
      a = base + 16'(4 * (i / 2));
      return i[0] ? ~a : a;
   endfunction : px
   function automatic logic [15:0] csc(input int y, input int u, input int v);
      int r, g, b;
      r = (y * 1024 + int'(rlp_pkg::K_RV) * (v - 128) + 512) >>> 10;
      g = (y * 1024 - int'(rlp_pkg::K_GU) * (u - 128) - int'(rlp_pkg::K_GV) * (v - 128)
         + 512) >>> 10;
      b = (y * 1024 + int'(rlp_pkg::K_BU) * (u - 128) + 512) >>> 10;
      r = r < 0 ? 0 : (r > 255 ? 255 : r);
      g = g < 0 ? 0 : (g > 255 ? 255 : g);
      b = b < 0 ? 0 : (b > 255 ? 255 : b);
      return {r[7:3], g[7:2], b[7:3]};
   endfunction : csc
   // panel side: the sample after a sync tick is the first pixel
   always @(posedge port_clk) begin
      if (rem > 0) begin
         cap.push_back(video_data);
         `CHK(fsync, 1'b0)
         rem = rem - 1;
      end else if (fsync === 1'b1) rem = 4;
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
   end
   initial begin
      logic [7:0] t;
      int hi;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(rlp_pkg::A_XCNT, 32'd120);
      rd(rlp_pkg::A_YCNT, 32'd329);
      rd(rlp_pkg::A_XMOD, 32'd4);
      rd(rlp_pkg::A_YMOD, 32'd4);
      rd(rlp_pkg::A_PDLY, 32'd0);
      rd(rlp_pkg::A_PCNT, 32'd239);
      rd(rlp_pkg::A_CTRL, 32'd0);
      ce <= 1'b0;
      wr(rlp_pkg::A_PCNT, 32'd5);
      ce <= 1'b1;
      rd(rlp_pkg::A_PCNT, 32'd239);
      wr(8'hFC, 32'hFFFF_FFFF);
      rd(8'hFC, 32'd0);
      for (int i = 0; i < 5; i++) begin
         wr(rlp_pkg::A_CSCI, {8'h00, v_t[i], u_t[i], y_t[i]});
         rd(rlp_pkg::A_CSCO, {16'h0, csc(y_t[i], u_t[i], v_t[i])});
      end
      wr(rlp_pkg::A_FDAT, 32'h100);
      wr(rlp_pkg::A_FDIR, 32'h100);
      #1 `CHK({f_oe, f_o}, 2'b11)
      wr(rlp_pkg::A_FDIR, 32'h0);
      ext_lvl <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(rlp_pkg::A_FDAT, 32'h100);
      for (int i = 0; i < 5; i++) begin
         t = rlp_pkg::A_TMR + rlp_pkg::TMR_STRIDE * i[7:0];
         wr(t + rlp_pkg::TMR_PER, 32'd10);
         wr(t + rlp_pkg::TMR_WID, i + 1);
         wr(t + rlp_pkg::TMR_CFG, {30'h0, i[0], 1'b1});
         repeat (25) @(posedge ref_clk);
         hi = 0;
         // four whole periods, so the count does not depend on phase
         repeat (40) begin
            @(negedge ref_clk);
            if (timing_out[i] === i[0]) hi++;
         end
         `CHK(hi, 4 * (i + 1))
         wr(t + rlp_pkg::TMR_CFG, {30'h0, i[0], 1'b0});
         repeat (3) @(negedge ref_clk);
         `CHK(timing_out[i], ~i[0])
      end
      wr(rlp_pkg::A_NDP, 32'h100);
      wr(rlp_pkg::A_XCNT, 32'd2);
      wr(rlp_pkg::A_YCNT, 32'd2);
      wr(rlp_pkg::A_PCNT, 32'd3);
      wr(rlp_pkg::A_MASK, 32'h1);
      wr(rlp_pkg::A_CTRL, 32'h1);
      wait_cap(8);
      repeat (4) @(negedge ref_clk);
      `CHK(irq, 1'b1)
      rd(rlp_pkg::A_STAT, 32'h1);
      wr(rlp_pkg::A_STAT, 32'h3);
      #1 `CHK(irq, 1'b0)
      wait_cap(10);
      wr(rlp_pkg::A_NDP, 32'h200);
      slow <= 1'b1;
      wait_cap(24);
      for (int i = 0; i < 24; i++) `CHK(cap[i], px(i < 16 ? 16'h2000 : 16'h3000, i % 8))
      rd(rlp_pkg::A_STAT, 32'h1);
      wr(rlp_pkg::A_MASK, 32'h0);
      #1 `CHK(irq, 1'b0)
      wr(rlp_pkg::A_CTRL, 32'h0);
      final_report();
   end
endmodule : testbench
